//--- core/dmrc_pkg.sv
// package: constants for the memory routing and encryption check block
package dmrc_pkg;
   // ----------------------------------------
   // address geometry
   // ----------------------------------------
   localparam int PA_W           = 52;
   localparam int LIMIT_LSB      = 23;
   localparam int LIMIT_MSB      = 51;
   localparam int LIMIT_W        = LIMIT_MSB - LIMIT_LSB + 1;
   localparam int FOUR_GB_LSB    = 32;
   localparam int CAP_W          = 32;
   localparam int CBIT_POS_W     = 6;
   localparam int REDUCE_W       = 6;
   // ----------------------------------------
   // system configuration register fields
   // ----------------------------------------
   localparam int CFG_LOW_EN_BIT  = 20;
   localparam int CFG_HIGH_EN_BIT = 21;
   localparam int CFG_ENC_EN_BIT  = 23;
   // ----------------------------------------
   // capability register fields
   // ----------------------------------------
   localparam int CAP_ENC_SUP_BIT = 0;
   localparam int CAP_CBIT_LSB    = 8;
   localparam int CAP_REDUCE_LSB  = 16;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [63:0] LIMIT_RST = 64'h0000_0000_0000_0000;
   localparam logic [31:0] CFG_RST   = 32'h0000_0000;
   // ----------------------------------------
   // memory types checked by the route table
   // ----------------------------------------
   localparam logic [2:0] MT_UC = 3'h0;
   localparam logic [2:0] MT_WC = 3'h1;
   localparam logic [2:0] MT_WT = 3'h4;
   localparam logic [2:0] MT_WP = 3'h5;
   localparam logic [2:0] MT_WB = 3'h6;
   // ----------------------------------------
   // translation walk states
   // ----------------------------------------
   typedef enum logic [1:0] {
      DMRC_IDLE,
      DMRC_CHECK,
      DMRC_DONE
   } dmrc_state_e;
endpackage

//--- core/dmrc_route_table.sv
// module: allowed read/write route versus memory type combinations
`timescale 1ns/1ns
module dmrc_route_table
   import dmrc_pkg::*;
(
   // combination in
   input  wire logic       i_read_route_bit,
   input  wire logic       i_write_route_bit,
   input  wire logic [2:0] i_mem_type,
   // verdict out
   output logic            o_allowed
);
   always_comb
   begin
      o_allowed = 1'b0;
      case ({i_read_route_bit, i_write_route_bit})
         2'b00:
         begin
            o_allowed = (i_mem_type == MT_UC) || (i_mem_type == MT_WC) ||
                        (i_mem_type == MT_WT) || (i_mem_type == MT_WP);
         end
         2'b01:
         begin
            // shadow fill: uncached only, every other type reserved
            o_allowed = (i_mem_type == MT_UC);
         end
         2'b10:
         begin
            o_allowed = (i_mem_type == MT_UC) || (i_mem_type == MT_WP);
         end
         2'b11:
         begin
            o_allowed = (i_mem_type == MT_UC) || (i_mem_type == MT_WC) ||
                        (i_mem_type == MT_WT) || (i_mem_type == MT_WB);
         end
         default:
         begin
            o_allowed = 1'b0;
         end
      endcase
   end
endmodule

//--- core/dmrc_top.sv
// module: physical address routing and encryption attribute checking
`timescale 1ns/1ns
module dmrc_top
   import dmrc_pkg::*;
#(
   parameter int                  CBIT_POS      = 47,
   parameter int                  REDUCE_BITS   = 5,
   parameter logic                ENC_SUPPORTED = 1'b1
)
(
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_srst,
   // register writes
   input  wire logic              i_low_limit_wr,
   input  wire logic              i_high_limit_wr,
   input  wire logic              i_cfg_wr,
   input  wire logic [63:0]       i_wr_data,
   // processor mode
   input  wire logic              i_paging_en,
   input  wire logic              i_physical_address_extension_control,
   input  wire logic              i_legacy_ext_mode,
   input  wire logic              i_system_management_mode,
   // access request
   input  wire logic              i_acc_valid,
   input  wire logic [PA_W-1:0]   i_acc_addr,
   input  wire logic              i_acc_write,
   input  wire logic              i_acc_enc_attr,
   input  wire logic [2:0]        i_acc_mem_type,
   input  wire logic              i_acc_read_route_bit,
   input  wire logic              i_acc_write_route_bit,
   input  wire logic              i_acc_range_hit,
   // translation entry check
   input  wire logic              i_pte_valid,
   input  wire logic [63:0]       i_pte,
   input  wire logic              i_pte_upper_level,
   input  wire logic              i_pte_is_pdpt_ptr,
   // register readback
   output logic [63:0]            o_low_memory_top_limit,
   output logic [63:0]            o_high_memory_top_limit,
   output logic [31:0]            o_system_configuration_register,
   output logic [CAP_W-1:0]       o_capability,
   // access result
   output logic                   o_acc_done,
   output logic                   o_acc_to_mem,
   output logic                   o_acc_encrypt,
   output logic                   o_acc_decrypt,
   output logic                   o_acc_combo_bad,
   output logic                   o_machine_check,
   // translation result
   output logic                   o_pte_done,
   output logic                   o_page_fault,
   output logic                   o_next_table_enc
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [LIMIT_W-1:0] low_lim_reg,  low_lim_next;
   logic [LIMIT_W-1:0] high_lim_reg, high_lim_next;
   logic [31:0]        cfg_reg,      cfg_next;

   always_comb
   begin
      low_lim_next  = i_low_limit_wr  ? i_wr_data[LIMIT_MSB:LIMIT_LSB] : low_lim_reg;
      high_lim_next = i_high_limit_wr ? i_wr_data[LIMIT_MSB:LIMIT_LSB] : high_lim_reg;
      cfg_next      = i_cfg_wr        ? i_wr_data[31:0]                : cfg_reg;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         low_lim_reg  <= LIMIT_RST[LIMIT_W-1:0];
         high_lim_reg <= LIMIT_RST[LIMIT_W-1:0];
         cfg_reg      <= CFG_RST;
      end
      else
      begin
         low_lim_reg  <= low_lim_next;
         high_lim_reg <= high_lim_next;
         cfg_reg      <= cfg_next;
      end
   end

   // ----------------------------------------
   // derived controls
   // ----------------------------------------
   logic low_en, high_en, enc_on, mode_ok;
   logic [PA_W-1:0] addr_mask;
   assign low_en  = cfg_reg[CFG_LOW_EN_BIT];
   assign high_en = cfg_reg[CFG_HIGH_EN_BIT];
   // key is internal to the cipher; nothing here can reach it
   assign enc_on  = ENC_SUPPORTED && cfg_reg[CFG_ENC_EN_BIT];
   // management mode needs nothing extra: same paging gate, same width limits
   assign mode_ok = i_paging_en && i_physical_address_extension_control;

   // reduced width mask, attribute bit always dropped when encryption is on
   always_comb
   begin
      addr_mask = '1;
      if (enc_on)
      begin
         for (int b = 0; b < PA_W; b++)
         begin
            if (b >= PA_W - REDUCE_BITS || b == CBIT_POS)
            begin
               addr_mask[b] = 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // routing
   // ----------------------------------------
   logic [PA_W-1:0] chk_addr;
   logic [PA_W-1:0] low_top, high_top;
   logic            below4g, to_mem, combo_ok;
   assign chk_addr = i_acc_addr & addr_mask;
   assign low_top  = {low_lim_reg,  {LIMIT_LSB{1'b0}}};
   assign high_top = {high_lim_reg, {LIMIT_LSB{1'b0}}};
   assign below4g  = (chk_addr[PA_W-1:FOUR_GB_LSB] == '0);

   assign to_mem = below4g ? (low_en && (chk_addr < low_top))
                           : (high_en && (chk_addr < high_top));

   dmrc_route_table u_table
   (
      .i_read_route_bit  (i_acc_read_route_bit),
      .i_write_route_bit (i_acc_write_route_bit),
      .i_mem_type        (i_acc_mem_type),
      .o_allowed         (combo_ok)
   );

   // ----------------------------------------
   // access result
   // ----------------------------------------
   logic acc_done_reg, acc_done_next, mem_reg, mem_next;
   logic enc_reg, enc_next, dec_reg, dec_next;
   logic bad_reg, bad_next, mce_reg, mce_next;
   logic acc_enc;
   // one attribute per page, page size does not matter
   assign acc_enc = enc_on && mode_ok && i_acc_enc_attr;

   always_comb
   begin
      acc_done_next = i_acc_valid;
      mem_next      = 1'b0;
      enc_next      = 1'b0;
      dec_next      = 1'b0;
      bad_next      = 1'b0;
      mce_next      = 1'b0;
      if (i_acc_valid)
      begin
         mem_next = to_mem;
         if (i_acc_range_hit)
         begin
            mem_next = i_acc_write ? i_acc_write_route_bit : i_acc_read_route_bit;
            bad_next = !combo_ok;
         end
         // encryption only on the memory path; toggling the attribute rewrites nothing
         enc_next = acc_enc && mem_next && i_acc_write;
         dec_next = acc_enc && mem_next && !i_acc_write;
         mce_next = acc_enc && !mem_next;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         acc_done_reg <= 1'b0;
         mem_reg      <= 1'b0;
         enc_reg      <= 1'b0;
         dec_reg      <= 1'b0;
         bad_reg      <= 1'b0;
         mce_reg      <= 1'b0;
      end
      else
      begin
         acc_done_reg <= acc_done_next;
         mem_reg      <= mem_next;
         enc_reg      <= enc_next;
         dec_reg      <= dec_next;
         bad_reg      <= bad_next;
         mce_reg      <= mce_next;
      end
   end

   // ----------------------------------------
   // translation entry check
   // ----------------------------------------
   dmrc_state_e state_reg, state_next;
   logic pte_done_reg, pte_done_next, pf_reg, pf_next, nte_reg, nte_next;
   logic [63:0] pte_hold_reg, pte_hold_next;
   logic        upper_reg, upper_next, pdpt_reg, pdpt_next;
   logic [63:0] rsv_mask;

   always_comb
   begin
      rsv_mask = '0;
      for (int b = 0; b < PA_W; b++)
      begin
         if (b >= PA_W - REDUCE_BITS && b != CBIT_POS)
         begin
            rsv_mask[b] = 1'b1;
         end
      end
   end

   always_comb
   begin
      state_next    = state_reg;
      pte_hold_next = pte_hold_reg;
      upper_next    = upper_reg;
      pdpt_next     = pdpt_reg;
      pte_done_next = 1'b0;
      pf_next       = 1'b0;
      nte_next      = 1'b0;
      case (state_reg)
         DMRC_IDLE:
         begin
            if (i_pte_valid)
            begin
               pte_hold_next = i_pte;
               upper_next    = i_pte_upper_level;
               pdpt_next     = i_pte_is_pdpt_ptr;
               state_next    = DMRC_CHECK;
            end
         end
         DMRC_CHECK:
         begin
            pte_done_next = 1'b1;
            pf_next = enc_on && ((pte_hold_reg & rsv_mask) != '0);
            // 32-bit base cannot carry an upper attribute bit
            nte_next = enc_on && mode_ok && upper_reg && pte_hold_reg[CBIT_POS] &&
                       !(i_legacy_ext_mode && pdpt_reg && CBIT_POS >= 32);
            state_next = DMRC_DONE;
         end
         DMRC_DONE:
         begin
            state_next = DMRC_IDLE;
         end
         default:
         begin
            state_next = DMRC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state_reg    <= DMRC_IDLE;
         pte_hold_reg <= '0;
         upper_reg    <= 1'b0;
         pdpt_reg     <= 1'b0;
         pte_done_reg <= 1'b0;
         pf_reg       <= 1'b0;
         nte_reg      <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         pte_hold_reg <= pte_hold_next;
         upper_reg    <= upper_next;
         pdpt_reg     <= pdpt_next;
         pte_done_reg <= pte_done_next;
         pf_reg       <= pf_next;
         nte_reg      <= nte_next;
      end
   end

   // ----------------------------------------
   // readback and capability
   // ----------------------------------------
   logic [CAP_W-1:0] cap_reg, cap_next;
   always_comb
   begin
      cap_next = '0;
      cap_next[CAP_ENC_SUP_BIT] = ENC_SUPPORTED;
      cap_next[CAP_CBIT_LSB +: CBIT_POS_W] = CBIT_POS_W'(CBIT_POS);
      cap_next[CAP_REDUCE_LSB +: REDUCE_W] = REDUCE_W'(REDUCE_BITS);
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         cap_reg <= '0;
      end
      else
      begin
         cap_reg <= cap_next;
      end
   end

   assign o_low_memory_top_limit  = {12'h000, low_lim_reg, 23'h0};
   assign o_high_memory_top_limit = {12'h000, high_lim_reg, 23'h0};
   assign o_system_configuration_register = cfg_reg;
   assign o_capability    = cap_reg;
   assign o_acc_done      = acc_done_reg;
   assign o_acc_to_mem    = mem_reg;
   assign o_acc_encrypt   = enc_reg;
   assign o_acc_decrypt   = dec_reg;
   assign o_acc_combo_bad = bad_reg;
   assign o_machine_check = mce_reg;
   assign o_pte_done      = pte_done_reg;
   assign o_page_fault    = pf_reg;
   assign o_next_table_enc = nte_reg;
endmodule

//--- tb/dmrc_top_asserts.sv
// checker: port-level properties of the routing and encryption check block
`timescale 1ns/1ns
module dmrc_top_asserts
   import dmrc_pkg::*;
(
   // clock and reset
   input  wire logic            i_sys_clk,
   input  wire logic            i_srst,
   // mode and request
   input  wire logic            i_paging_en,
   input  wire logic            i_physical_address_extension_control,
   input  wire logic            i_acc_valid,
   input  wire logic [PA_W-1:0] i_acc_addr,
   input  wire logic            i_acc_enc_attr,
   input  wire logic            i_acc_range_hit,
   input  wire logic            i_pte_valid,
   input  wire logic [63:0]     i_pte,
   // design outputs
   input  wire logic [63:0]     o_low_memory_top_limit,
   input  wire logic [63:0]     o_high_memory_top_limit,
   input  wire logic [31:0]     o_system_configuration_register,
   input  wire logic            o_acc_to_mem,
   input  wire logic            o_acc_encrypt,
   input  wire logic            o_acc_decrypt,
   input  wire logic            o_machine_check,
   input  wire logic            o_pte_done,
   input  wire logic            o_page_fault
);
   localparam logic [63:0] LIM_M = 64'h000F_FFFF_FF80_0000;
   // upper address bits kept zero here so masking cannot blur the verdict
   wire logic en_on = o_system_configuration_register[23] & i_paging_en
                      & i_physical_address_extension_control;
   wire logic lo_plain = i_acc_valid & ~i_acc_range_hit & (i_acc_addr[51:32] == 20'h0_0000);
   wire logic hi_plain = i_acc_valid & ~i_acc_range_hit & (i_acc_addr[51:47] == 5'h00)
                         & (|i_acc_addr[46:32]);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);
   // ----------------------------------------
   // routing
   // ----------------------------------------
   property p_low_mem;
      lo_plain && o_system_configuration_register[20]
         && (i_acc_addr < o_low_memory_top_limit[51:0]) |=> o_acc_to_mem;
   endproperty
   a_low_mem: assert property (p_low_mem)
      else $error("low region access not sent to memory");
   property p_low_io;
      lo_plain && (!o_system_configuration_register[20]
         || i_acc_addr >= o_low_memory_top_limit[51:0]) |=> !o_acc_to_mem;
   endproperty
   a_low_io: assert property (p_low_io)
      else $error("low hole access not sent to io");
   property p_high_mem;
      hi_plain && o_system_configuration_register[21]
         && (i_acc_addr < o_high_memory_top_limit[51:0]) |=> o_acc_to_mem;
   endproperty
   a_high_mem: assert property (p_high_mem)
      else $error("high region access not sent to memory");
   property p_high_io;
      hi_plain && (!o_system_configuration_register[21]
         || i_acc_addr >= o_high_memory_top_limit[51:0]) |=> !o_acc_to_mem;
   endproperty
   a_high_io: assert property (p_high_io)
      else $error("high top access not sent to io");
   property p_lim_bits;
      ((o_low_memory_top_limit | o_high_memory_top_limit) & ~LIM_M) == 64'h0;
   endproperty
   a_lim_bits: assert property (p_lim_bits)
      else $error("limit register keeps ignored bits");
   // ----------------------------------------
   // encryption
   // ----------------------------------------
   property p_enc_gate;
      i_acc_valid && !en_on |=> !(o_acc_encrypt || o_acc_decrypt || o_machine_check);
   endproperty
   a_enc_gate: assert property (p_enc_gate)
      else $error("encryption active while disabled");
   property p_mc;
      i_acc_valid && i_acc_enc_attr && en_on |=> o_machine_check == !o_acc_to_mem;
   endproperty
   a_mc: assert property (p_mc)
      else $error("machine check does not match io routing");
   sequence s_bad_entry;
      i_pte_valid && en_on && (i_pte[51:48] != 4'h0);
   endsequence
   sequence s_fault_out;
      !o_pte_done ##1 (o_pte_done && o_page_fault);
   endsequence
   property p_fault;
      s_bad_entry |=> s_fault_out;
   endproperty
   a_fault: assert property (p_fault)
      else $error("reserved entry bits gave no page fault");
   property p_fault_off;
      i_pte_valid && !o_system_configuration_register[23] |-> ##2 !o_page_fault;
   endproperty
   a_fault_off: assert property (p_fault_off)
      else $error("page fault while encryption off");
endmodule

bind dmrc_top dmrc_top_asserts u_asserts (.*);

//--- tb/dmrc_fabric_model.sv
// model: memory and io fabric that tallies routed transfers
`timescale 1ns/1ns
module dmrc_fabric_model
(
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_srst,
   // routed transfer
   input  wire logic i_acc_done,
   input  wire logic i_acc_to_mem,
   // tallies
   output int        o_mem_cnt,
   output int        o_io_cnt
);
   // the fabric never stalls: the router has no back-pressure input
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         o_mem_cnt <= 0;
         o_io_cnt  <= 0;
      end
      else if (i_acc_done === 1'b1)
      begin
         if (i_acc_to_mem === 1'b1)
            o_mem_cnt <= o_mem_cnt + 1;
         else
            o_io_cnt <= o_io_cnt + 1;
      end
   end
endmodule

//--- tb/dmrc_top_bench.sv
// bench: routing, limit and encryption checks through the block ports
`timescale 1ns/1ns
module dmrc_top_bench;
   import dmrc_pkg::*;
   logic i_sys_clk = 1'b0, i_srst = 1'b1, i_low_limit_wr, i_high_limit_wr, i_cfg_wr;
   logic i_paging_en, i_physical_address_extension_control, i_legacy_ext_mode;
   logic i_system_management_mode, i_acc_valid, i_acc_write, i_acc_enc_attr;
   logic i_acc_read_route_bit, i_acc_write_route_bit, i_acc_range_hit;
   logic i_pte_valid, i_pte_upper_level, i_pte_is_pdpt_ptr;
   logic o_acc_done, o_acc_to_mem, o_acc_encrypt, o_acc_decrypt, o_acc_combo_bad;
   logic o_machine_check, o_pte_done, o_page_fault, o_next_table_enc;
   logic [63:0] i_wr_data, i_pte, o_low_memory_top_limit, o_high_memory_top_limit, r, lo, hi;
   logic [PA_W-1:0] i_acc_addr;
   logic [2:0]  i_acc_mem_type;
   logic [31:0] o_system_configuration_register, o_capability, cfg;
   logic [4:0]  acc_q[$];
   logic [1:0]  pte_q[$];
   logic [4:0]  hc[14] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0E,
                           5'h10, 5'h11, 5'h15, 5'h18, 5'h19, 5'h1D, 5'h1E};
   logic [51:0] bnd[8] = '{52'h0, 52'h407F_FFFF, 52'h4080_0000, 52'hFFFF_FFFF,
                           52'h1_0000_0000, 52'h1_FFFF_FFFF, 52'h2_0000_0000, '1};
   int err_total = 0, cmp_count = 0, n_acc = 0, mem_cnt, io_cnt;

   dmrc_top uut (.*);
   dmrc_fabric_model fab (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_acc_done(o_acc_done),
                          .i_acc_to_mem(o_acc_to_mem), .o_mem_cnt(mem_cnt), .o_io_cnt(io_cnt));

   always #25 i_sys_clk = ~i_sys_clk;

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic tick();
      @(posedge i_sys_clk);
      #2;
   endtask

   // strobe then one quiet cycle, so a following write never re-raises in the same step
   // also drops a raised access so no stray request rides along
   task automatic wr(input logic [2:0] s, input logic [63:0] d);
      i_acc_valid = 1'b0;
      {i_low_limit_wr, i_high_limit_wr, i_cfg_wr} = s;
      i_wr_data = d;
      if (s[2]) lo = d & 64'h000F_FFFF_FF80_0000;
      if (s[1]) hi = d & 64'h000F_FFFF_FF80_0000;
      if (s[0]) cfg = d[31:0];
      tick();
      {i_low_limit_wr, i_high_limit_wr, i_cfg_wr} = 3'b000;
      tick();
   endtask

   // leaves the request raised so accesses can run back to back
   task automatic acc(input logic [51:0] a, input logic w, input logic c);
      logic [51:0] m;
      logic [1:0]  rw;
      logic        en;
      logic        mem;
      logic        bad;
      en  = cfg[23] & i_paging_en & i_physical_address_extension_control;
      // width reduction follows the enable bit alone, paging gates only the cipher
      m   = cfg[23] ? (a & 52'h0_7FFF_FFFF_FFFF) : a;
      rw  = {i_acc_read_route_bit, i_acc_write_route_bit};
      bad = i_acc_range_hit & !((i_acc_mem_type == MT_UC)
            || (rw == 2'b00 && (i_acc_mem_type == MT_WC || i_acc_mem_type == MT_WT
                                || i_acc_mem_type == MT_WP))
            || (rw == 2'b10 && i_acc_mem_type == MT_WP)
            || (rw == 2'b11 && (i_acc_mem_type == MT_WC || i_acc_mem_type == MT_WT
                                || i_acc_mem_type == MT_WB)));
      if (i_acc_range_hit)
         mem = w ? rw[0] : rw[1];
      else if (m[51:32] == 20'h0_0000)
         mem = cfg[20] & (m < lo[51:0]);
      else
         mem = cfg[21] & (m < hi[51:0]);
      acc_q.push_back({mem, en & c & mem & w, en & c & mem & ~w, bad, en & c & ~mem});
      {i_acc_addr, i_acc_write, i_acc_enc_attr, i_acc_valid} = {a, w, c, 1'b1};
      n_acc++;
      tick();
   endtask

   task automatic idle();
      i_acc_valid = 1'b0;
      tick();
   endtask

   task automatic pte(input logic [63:0] e, input logic up, input logic pd, input logic [1:0] x);
      pte_q.push_back(x);
      {i_pte, i_pte_upper_level, i_pte_is_pdpt_ptr, i_pte_valid} = {e, up, pd, 1'b1};
      tick();
      i_pte_valid = 1'b0;
      tick();
      tick();
   endtask

   always @(negedge i_sys_clk)
   begin
      if (o_acc_done === 1'b1)
         chk("access", acc_q.size() ? acc_q.pop_front() : 64'hx, {o_acc_to_mem,
             o_acc_encrypt, o_acc_decrypt, o_acc_combo_bad, o_machine_check});
      if (o_pte_done === 1'b1)
         chk("entry", pte_q.size() ? pte_q.pop_front() : 64'hx,
             {o_page_fault, o_next_table_enc});
   end

   initial
   begin
      #200_000;
      err_total++;
      final_report();
   end

   initial
   begin
      {i_low_limit_wr, i_high_limit_wr, i_cfg_wr, i_acc_valid, i_pte_valid} = 5'h00;
      {i_paging_en, i_physical_address_extension_control, i_legacy_ext_mode} = 3'h0;
      {i_system_management_mode, i_acc_write, i_acc_enc_attr, i_acc_range_hit} = 4'h0;
      {i_acc_read_route_bit, i_acc_write_route_bit, i_pte_upper_level, i_pte_is_pdpt_ptr} = 4'h0;
      {i_wr_data, i_pte, i_acc_addr, i_acc_mem_type, lo, hi, cfg} = '0;
      void'($urandom(85615));
      repeat (6) @(posedge i_sys_clk);
      #2 i_srst = 1'b0;
      tick();
      chk("capability", 64'h0005_2F01, o_capability);
      acc(52'h1000, 1'b0, 1'b0);
      acc(52'h1_0000_1000, 1'b1, 1'b0);
      wr(3'b100, 64'hFFF0_0000_4080_0123);
      wr(3'b010, 64'hF000_0002_0000_7FFF);
      chk("low limit", 64'h0000_0000_4080_0000, o_low_memory_top_limit);
      chk("high limit", 64'h0000_0002_0000_0000, o_high_memory_top_limit);
      acc(52'h1000, 1'b1, 1'b0);
      acc(52'h1_0000_1000, 1'b0, 1'b0);
      wr(3'b001, 64'h0000_0000_0030_0000);
      chk("config", 64'h0000_0000_0030_0000, o_system_configuration_register);
      foreach (bnd[k])
         acc(bnd[k], k[0], 1'b0);
      wr(3'b001, 64'h0000_0000_00B0_0000);
      repeat (40)
      begin
         r = {$urandom(), $urandom()};
         i_paging_en = r[40];
         i_physical_address_extension_control = r[41];
         i_system_management_mode = r[44];
         acc(r[51:0] & 52'h0_8003_FFFF_FFFF, r[42], r[43]);
      end
      i_acc_range_hit = 1'b1;
      foreach (hc[k])
      begin
         {i_acc_read_route_bit, i_acc_write_route_bit, i_acc_mem_type} = hc[k];
         acc(52'h2000, 1'b0, 1'b0);
         acc(52'h2000, 1'b1, 1'b0);
      end
      idle();
      {i_acc_range_hit, i_paging_en, i_physical_address_extension_control} = 3'b011;
      pte(64'h0004_0000_0000_1003, 1'b0, 1'b0, 2'b10);
      pte(64'h0000_8000_0000_1003, 1'b1, 1'b0, 2'b01);
      pte(64'h0000_8000_0000_1083, 1'b0, 1'b0, 2'b00);
      i_legacy_ext_mode = 1'b1;
      pte(64'h0000_8000_0000_1003, 1'b1, 1'b1, 2'b00);
      i_legacy_ext_mode = 1'b0;
      wr(3'b001, 64'h0000_0000_0030_0000);
      pte(64'h0004_8000_0000_1003, 1'b1, 1'b0, 2'b00);
      tick();
      chk("pending", 64'h0, acc_q.size() + pte_q.size());
      chk("fabric", n_acc, mem_cnt + io_cnt);
      final_report();
   end
endmodule
